// ### sdram_mux_pkg.sv
// Contract
// R1 - Every module access is a four-beat burst moving one 288-bit cache line.
// R2 - Each port word is 72 bits: 64 data bits and 8 check bits.
// R3 - With two carriers, this carrier answers only its own cache line parity.
// R4 - With one carrier, every address is answered without interleaving.
// R5 - Each control input is registered and driven out as two copies.
// R6 - Registered control inputs are decoded into port selects and direction enables.
// R7 - Reads act as a registered four-to-one mux onto the controller bus.
// R8 - Writes drive controller data to exactly one selected memory port.
// R9 - Bursts always cover four beats, one per memory data port.
// R10 - Read and write directions each have their own internal output enable.
// R11 - Read data is captured into per-port registers on the rising edge.
// R12 - A two-bit internal select picks the captured port for the controller.
// R13 - Controller read data comes from a register, valid a full period.
// R14 - Write data loads per-port registers, then the write enable drives it.
// R15 - All control inputs are registered; everything advances on one clock.
// R16 - The controller corrects single-bit and detects double-bit errors.
// R17 - All 72 bits pass unchanged in both directions.
package sdram_mux_pkg;

	// =========================================================
	// Widths
	localparam int DATA_W  = 64;
	localparam int CHECK_W = 8;
	localparam int WORD_W  = DATA_W + CHECK_W; // R2
	localparam int PORT_N  = 4;
	localparam int SEL_W   = 2;
	localparam int ADDR_W  = 14;
	localparam int BANK_W  = 2;

	// =========================================================
	// Types
	typedef logic [WORD_W-1:0] word_t;
	typedef logic [SEL_W-1:0]  sel_t;

	typedef struct packed {
		logic              cs_n;
		logic              ras_n;
		logic              cas_n;
		logic              we_n;
		logic [BANK_W-1:0] bank;
		logic [ADDR_W-1:0] addr;
		logic              line_odd;
	} ctrl_t;

	typedef enum logic [1:0] {
		SEQ_IDLE  = 2'b00,
		SEQ_READ  = 2'b01,
		SEQ_WRITE = 2'b10
	} seq_state_t;

	// =========================================================
	// Reset values and counts
	localparam ctrl_t CTRL_RESET = '{cs_n: 1'h1, ras_n: 1'h1, cas_n: 1'h1, we_n: 1'h1,
		bank: 2'h0, addr: 14'h0000, line_odd: 1'h0};
	localparam word_t WORD_RESET = 72'h0;
	localparam sel_t  SEL_FIRST  = 2'h0;
	localparam sel_t  SEL_LAST   = 2'h3;
	localparam sel_t  SEL_STEP   = 2'h1;

	// =========================================================
	// Command decode
	function automatic logic is_column(input ctrl_t c);
		return !c.cs_n && c.ras_n && !c.cas_n;
	endfunction

	function automatic logic is_read(input ctrl_t c);
		return is_column(c) && c.we_n;
	endfunction

	function automatic logic is_write(input ctrl_t c);
		return is_column(c) && !c.we_n;
	endfunction

	function automatic logic port_hit(input sel_t s, input int p);
		return s == p[SEL_W-1:0];
	endfunction

endpackage

// ### beat_sequencer.sv
`timescale 1ns/1ps
module beat_sequencer (
	// Clock and reset
	input  wire  logic                clk_i,
	input  wire  logic                rst_n_i,
	// Start request
	input  wire  logic                start_i,
	input  wire  logic                write_i,
	// Beat state
	output logic                      active_o,
	output logic                      write_o,
	output sdram_mux_pkg::sel_t       sel_o
);

	// =========================================================
	// Burst state
	sdram_mux_pkg::seq_state_t state_q;
	sdram_mux_pkg::sel_t       sel_q;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= sdram_mux_pkg::SEQ_IDLE;
			sel_q   <= sdram_mux_pkg::SEL_FIRST;
		end else begin
			case (state_q)
				sdram_mux_pkg::SEQ_IDLE: begin
					sel_q <= sdram_mux_pkg::SEL_FIRST;
					if (start_i) begin
						state_q <= write_i ? sdram_mux_pkg::SEQ_WRITE : sdram_mux_pkg::SEQ_READ;
					end
				end
				sdram_mux_pkg::SEQ_READ, sdram_mux_pkg::SEQ_WRITE: begin
					sel_q <= sel_q + sdram_mux_pkg::SEL_STEP; // R9
					if (sel_q == sdram_mux_pkg::SEL_LAST) begin
						state_q <= sdram_mux_pkg::SEQ_IDLE; // R1
					end
				end
				default: begin
					state_q <= sdram_mux_pkg::SEQ_IDLE;
					sel_q   <= sdram_mux_pkg::SEL_FIRST;
				end
			endcase
		end
	end

	assign active_o = state_q != sdram_mux_pkg::SEQ_IDLE;
	assign write_o  = state_q == sdram_mux_pkg::SEQ_WRITE;
	assign sel_o    = sel_q;

	// =========================================================
	// Checks
	a_sel_in_idle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!active_o |=> !active_o || sel_o == 2'h0) // R12
		else $error("burst did not start at port zero");

endmodule // beat_sequencer

// ### sdram_pipeline_mux.sv
`timescale 1ns/1ps
module sdram_pipeline_mux (
	// Clock and reset
	input  wire  logic                                        SYS_CLK_I,
	input  wire  logic                                        RST_N_I,
	// Carrier configuration
	input  wire  logic                                        TWO_CARRIERS_I,
	input  wire  logic                                        ODD_CARRIER_I,
	// Controller side
	input  wire  sdram_mux_pkg::ctrl_t                        CTRL_I,
	input  wire  sdram_mux_pkg::word_t                        WR_DATA_I,
	output sdram_mux_pkg::word_t                              RD_DATA_O,
	output logic                                              RD_OE_O,
	// Memory control copies
	output sdram_mux_pkg::ctrl_t                              MEM_CTRL_A_O,
	output sdram_mux_pkg::ctrl_t                              MEM_CTRL_B_O,
	// Memory data ports
	input  wire  sdram_mux_pkg::word_t [sdram_mux_pkg::PORT_N-1:0] MEM_DQ_I,
	output sdram_mux_pkg::word_t [sdram_mux_pkg::PORT_N-1:0]       MEM_DQ_O,
	output logic [sdram_mux_pkg::PORT_N-1:0]                       MEM_DQ_OE_O
);

	// =========================================================
	// Declarations
	sdram_mux_pkg::ctrl_t                              ctrl_q;
	logic                                              two_q;
	logic                                              odd_q;
	logic                                              cmd_rd;
	logic                                              cmd_wr;
	logic                                              line_ok;
	logic                                              seq_start;
	logic                                              active;
	logic                                              write;
	sdram_mux_pkg::sel_t                               sel;
	sdram_mux_pkg::word_t [sdram_mux_pkg::PORT_N-1:0]  port_q;
	logic [sdram_mux_pkg::PORT_N-1:0]                  wr_oe_q;
	logic                                              rd_cap_q;
	sdram_mux_pkg::sel_t                               rd_sel_q;
	sdram_mux_pkg::word_t                              cap_word;
	logic                                              wr_beat;
	logic                                              rd_beat;
	logic [2:0]                                        rd_run_q;
	logic [2:0]                                        wr_run_q;

	// =========================================================
	// Control fanout
	always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			MEM_CTRL_A_O <= sdram_mux_pkg::CTRL_RESET;
			MEM_CTRL_B_O <= sdram_mux_pkg::CTRL_RESET;
			ctrl_q       <= sdram_mux_pkg::CTRL_RESET;
		end else begin
			MEM_CTRL_A_O <= CTRL_I; // R5
			MEM_CTRL_B_O <= CTRL_I; // R5
			ctrl_q       <= CTRL_I; // R15
		end
	end

	// =========================================================
	// Carrier configuration
	always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			two_q <= 1'h0;
			odd_q <= 1'h0;
		end else begin
			two_q <= TWO_CARRIERS_I;
			odd_q <= ODD_CARRIER_I;
		end
	end

	// =========================================================
	// Steering decode
	assign cmd_rd    = sdram_mux_pkg::is_read(ctrl_q); // R6
	assign cmd_wr    = sdram_mux_pkg::is_write(ctrl_q); // R6
	assign line_ok   = !two_q || (ctrl_q.line_odd == odd_q); // R3 R4
	assign seq_start = (cmd_rd || cmd_wr) && line_ok && !active;

	beat_sequencer u_seq (
		.clk_i    (SYS_CLK_I),
		.rst_n_i  (RST_N_I),
		.start_i  (seq_start),
		.write_i  (cmd_wr),
		.active_o (active),
		.write_o  (write),
		.sel_o    (sel)
	);

	// =========================================================
	// Per-port registers
	always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			for (int p = 0; p < sdram_mux_pkg::PORT_N; p++) begin
				port_q[p]  <= sdram_mux_pkg::WORD_RESET;
				wr_oe_q[p] <= 1'h0;
			end
		end else begin
			for (int p = 0; p < sdram_mux_pkg::PORT_N; p++) begin
				wr_oe_q[p] <= active && write && sdram_mux_pkg::port_hit(sel, p); // R8 R10
				if (active && write && sdram_mux_pkg::port_hit(sel, p)) begin
					port_q[p] <= WR_DATA_I; // R14 R17
				end else if (active && !write) begin
					port_q[p] <= MEM_DQ_I[p]; // R11 R17
				end
			end
		end
	end

	assign MEM_DQ_O    = port_q; // R14
	assign MEM_DQ_OE_O = wr_oe_q; // R10

	// =========================================================
	// Read select stage
	always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			rd_cap_q <= 1'h0;
			rd_sel_q <= sdram_mux_pkg::SEL_FIRST;
		end else begin
			rd_cap_q <= active && !write;
			rd_sel_q <= sel; // R12
		end
	end

	// =========================================================
	// Controller read output
	always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			RD_DATA_O <= sdram_mux_pkg::WORD_RESET;
			RD_OE_O   <= 1'h0;
		end else begin
			RD_OE_O <= rd_cap_q; // R10
			if (rd_cap_q) begin
				RD_DATA_O <= port_q[rd_sel_q]; // R7 R13
			end
		end
	end

	// =========================================================
	// Check helpers
	assign cap_word = MEM_DQ_I[sel];
	assign wr_beat  = active && write;
	assign rd_beat  = active && !write;

	// =========================================================
	// Beat run counters
	always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			rd_run_q <= 3'h0;
			wr_run_q <= 3'h0;
		end else begin
			rd_run_q <= RD_OE_O ? rd_run_q + 3'h1 : 3'h0;
			wr_run_q <= (|MEM_DQ_OE_O) ? wr_run_q + 3'h1 : 3'h0;
		end
	end

	sequence s_four_beats;
		active [*4] ##1 !active;
	endsequence

	sequence s_sel_walk;
		sel == 2'h0 ##1 sel == 2'h1 ##1 sel == 2'h2 ##1 sel == 2'h3;
	endsequence

	sequence s_read_oe_run;
		!RD_OE_O ##1 RD_OE_O [*4] ##1 !RD_OE_O;
	endsequence

	sequence s_read_run_gap;
		RD_OE_O [*4] ##1 !RD_OE_O;
	endsequence

	sequence s_write_run_gap;
		(|MEM_DQ_OE_O) [*4] ##1 !(|MEM_DQ_OE_O);
	endsequence

	// =========================================================
	// Checks
	a_ctrl_copy_pair: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R5
		##1 (MEM_CTRL_A_O == MEM_CTRL_B_O) && (MEM_CTRL_A_O == $past(CTRL_I)))
		else $error("control copies differ from registered input");

	a_burst_four_beats: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R1
		seq_start |=> s_four_beats)
		else $error("burst is not four beats long");

	a_port_select_walk: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R12
		seq_start |=> s_sel_walk)
		else $error("port select did not walk all four ports");

	a_read_oe_burst: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R10
		(seq_start && cmd_rd) |=> ##1 s_read_oe_run)
		else $error("read enable not asserted for four beats");

	a_read_oe_cause: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R10
		RD_OE_O |-> $past(active, 2) && !$past(write, 2))
		else $error("read enable without a read beat");

	a_read_path_data: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R7
		RD_OE_O |-> RD_DATA_O == $past(cap_word, 2))
		else $error("read data does not match selected port");

	a_read_hold: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R13
		!$past(rd_cap_q) |-> $stable(RD_DATA_O))
		else $error("read data changed outside a beat");

	a_write_one_port: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R8
		$onehot0(MEM_DQ_OE_O))
		else $error("more than one memory port driven");

	a_write_count: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R9
		(seq_start && cmd_wr) |=> ##1 (MEM_DQ_OE_O == 4'h1) ##1 (MEM_DQ_OE_O == 4'h2)
		##1 (MEM_DQ_OE_O == 4'h4) ##1 (MEM_DQ_OE_O == 4'h8) ##1 (MEM_DQ_OE_O == 4'h0))
		else $error("write beats did not cover ports in order");

	a_no_dir_overlap: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R10
		|MEM_DQ_OE_O |-> !rd_cap_q)
		else $error("both directions active");

	a_interleave_refuse: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R3
		(two_q && (cmd_rd || cmd_wr) && (ctrl_q.line_odd != odd_q) && !active) |=> !active)
		else $error("foreign cache line was answered");

	a_single_accept: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R4
		(!two_q && (cmd_rd || cmd_wr) && !active) |=> active)
		else $error("single carrier ignored a command");

	a_decode_dir: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R6
		seq_start |=> write == $past(cmd_wr))
		else $error("direction decode mismatch");

	a_read_run_gap: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R9
		$rose(RD_OE_O) |-> s_read_run_gap)
		else $error("read beats not four in a row");

	a_write_run_gap: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R9
		$rose(|MEM_DQ_OE_O) |-> s_write_run_gap)
		else $error("write beats not four in a row");

	a_read_run_len: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R9
		RD_OE_O |-> rd_run_q < 3'h4)
		else $error("read enable ran past four beats");

	a_write_run_len: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R9
		(|MEM_DQ_OE_O) |-> wr_run_q < 3'h4)
		else $error("write enable ran past four beats");

	a_interleave_accept: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R3
		(two_q && (cmd_rd || cmd_wr) && (ctrl_q.line_odd == odd_q) && !active) |=> active)
		else $error("own cache line was not answered");

	a_config_sample: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R15
		##1 (two_q == $past(TWO_CARRIERS_I)) && (odd_q == $past(ODD_CARRIER_I)))
		else $error("carrier mode not registered");

	a_read_no_drive: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R10
		rd_beat |=> (MEM_DQ_OE_O == 4'h0))
		else $error("memory port driven during a read");

	a_write_no_read_oe: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R10
		wr_beat |=> ##1 !RD_OE_O)
		else $error("read enable during a write");

	a_burst_dir_fixed: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R1
		(active && (sel != 2'h3)) |=> active && (write == $past(write)))
		else $error("burst changed direction or ended early");

	a_idle_quiet: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R10
		!active |=> !rd_cap_q && (MEM_DQ_OE_O == 4'h0))
		else $error("enable raised outside a burst");

	a_read_oe_start: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R6
		$rose(RD_OE_O) |-> $past(seq_start, 3) && $past(cmd_rd, 3))
		else $error("read enable without a decoded read");

	a_write_oe_start: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R6
		$rose(MEM_DQ_OE_O[0]) |-> $past(seq_start, 2) && $past(cmd_wr, 2))
		else $error("write enable without a decoded write");

	generate
		for (genvar g = 0; g < sdram_mux_pkg::PORT_N; g++) begin : g_port_chk
			a_write_port_data: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R14
				MEM_DQ_OE_O[g] |-> (MEM_DQ_O[g] == $past(WR_DATA_I)) && ($past(sel) == g))
				else $error("write port data mismatch");

			a_read_capture: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R11
				($past(active) && !$past(write)) |-> port_q[g] == $past(MEM_DQ_I[g]))
				else $error("read capture mismatch");

			a_port_hold: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R14
				(!(wr_beat && sdram_mux_pkg::port_hit(sel, g)) && !rd_beat)
				|=> $stable(MEM_DQ_O[g]))
				else $error("port register changed without a beat");

			a_port_write_hold: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R14
				$fell(MEM_DQ_OE_O[g]) |-> $stable(MEM_DQ_O[g]))
				else $error("written word did not stand after its beat");
		end
	endgenerate

endmodule // sdram_pipeline_mux

// ### mem_array_model.sv
`timescale 1ns/1ps
module mem_array_model (
	// Clock and reset
	input  wire logic                          clk_i,
	input  wire logic                          rst_n_i,
	// Control copy and read pattern
	input  wire sdram_mux_pkg::ctrl_t          ctrl_i,
	input  wire sdram_mux_pkg::word_t [3:0]    pat_i,
	// Port data
	output sdram_mux_pkg::word_t [3:0]         dq_o
);
	// ==========
	// Burst timing
	logic [2:0] beat_q;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			beat_q <= 3'h0;
		end else if (!ctrl_i.cs_n && ctrl_i.ras_n && !ctrl_i.cas_n && ctrl_i.we_n) begin
			beat_q <= 3'h4;
		end else if (beat_q != 3'h0) begin
			beat_q <= beat_q - 3'h1;
		end
	end

	// Outside a burst the lines show the inverse
	assign dq_o = (beat_q != 3'h0) ? pat_i : ~pat_i;
endmodule // mem_array_model

// ### tb.sv
`timescale 1ns/1ps
module tb;
	// ==========
	// Signals
	typedef struct packed {
		logic [1:0] kind;
		logic       two;
		logic       odd;
		logic       lodd;
		logic       extra;
		logic       acc;
	} row_t;

	logic                       sys_clk;
	logic                       rst_n;
	logic                       two_car;
	logic                       odd_car;
	logic                       rd_oe;
	logic [3:0]                 dq_oe;
	sdram_mux_pkg::ctrl_t       ctrl;
	sdram_mux_pkg::ctrl_t       ctrl_a;
	sdram_mux_pkg::ctrl_t       ctrl_b;
	sdram_mux_pkg::word_t       wr_data;
	sdram_mux_pkg::word_t       rd_data;
	sdram_mux_pkg::word_t [3:0] dq_in;
	sdram_mux_pkg::word_t [3:0] dq_out;
	sdram_mux_pkg::word_t [3:0] pat;
	int                         bad_count;
	int                         checks;
	// Kind 0 read, 1 write, 2 activate
	row_t                       rows [8] = '{7'h21, 7'h07, 7'h31, 7'h14,
		7'h1D, 7'h38, 7'h40, 7'h27};

	// ==========
	// Instances
	sdram_pipeline_mux DUT (
		.SYS_CLK_I      (sys_clk),
		.RST_N_I        (rst_n),
		.TWO_CARRIERS_I (two_car),
		.ODD_CARRIER_I  (odd_car),
		.CTRL_I         (ctrl),
		.WR_DATA_I      (wr_data),
		.RD_DATA_O      (rd_data),
		.RD_OE_O        (rd_oe),
		.MEM_CTRL_A_O   (ctrl_a),
		.MEM_CTRL_B_O   (ctrl_b),
		.MEM_DQ_I       (dq_in),
		.MEM_DQ_O       (dq_out),
		.MEM_DQ_OE_O    (dq_oe)
	);

	mem_array_model u_mem (
		.clk_i   (sys_clk),
		.rst_n_i (rst_n),
		.ctrl_i  (ctrl_a),
		.pat_i   (pat),
		.dq_o    (dq_in)
	);

	// ==========
	// Helpers
	initial begin
		sys_clk = 1'h0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	function automatic sdram_mux_pkg::word_t wd(int k);
		return {8'(8'h3C + k), 64'hF0E1D2C3B4A59687 + 64'(k)};
	endfunction

	function automatic sdram_mux_pkg::ctrl_t mk(logic [1:0] kind, logic lodd, int i);
		sdram_mux_pkg::ctrl_t c;
		c = sdram_mux_pkg::CTRL_RESET;
		c.cs_n = 1'h0;
		c.ras_n = (kind != 2'h2);
		c.cas_n = (kind == 2'h2);
		c.we_n = (kind != 2'h1);
		c.bank = i[1:0];
		c.addr = 14'h1ABC ^ 14'(i);
		c.line_odd = lodd;
		return c;
	endfunction

	task automatic cmp_w(string name, logic [71:0] exp, logic [71:0] got);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic cmp_f(string name, logic [3:0] exp, logic [3:0] got);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic final_report;
		$display("checks %0d errors %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// One command, nine cycles, checked each falling edge
	task automatic run_row(row_t r, int i);
		sdram_mux_pkg::ctrl_t c;
		logic [3:0]           exp_oe;
		logic                 exp_rd;
		c = mk(r.kind, r.lodd, i);
		two_car = r.two;
		odd_car = r.odd;
		for (int p = 0; p < 4; p++) begin
			pat[p] = ~wd(p + 8 * i);
		end
		for (int n = 0; n < 9; n++) begin
			@(negedge sys_clk);
			if (n == 1) begin
				cmp_w("ctrl_a", 72'(c), 72'(ctrl_a));
				cmp_w("ctrl_b", 72'(c), 72'(ctrl_b));
			end
			ctrl = (n == 0) ? c : (n == 2 && r.extra) ? mk(2'h1, r.lodd, i) :
				sdram_mux_pkg::CTRL_RESET;
			wr_data = wd(n - 2 + 8 * i);
			exp_oe = (r.kind == 2'h1 && r.acc && n >= 3 && n <= 6) ? 4'(1 << (n - 3)) : 4'h0;
			exp_rd = (r.kind == 2'h0 && r.acc && n >= 4 && n <= 7);
			cmp_f("dq_oe", exp_oe, dq_oe);
			if (exp_oe != 4'h0) begin
				cmp_w("dq_out", wd(n - 3 + 8 * i), dq_out[n - 3]);
			end
			cmp_f("rd_oe", 4'(exp_rd), {3'h0, rd_oe});
			if (exp_rd) begin
				cmp_w("rd_data", pat[n - 4], rd_data);
				cmp_w("rd_check", 72'(pat[n - 4][71:64]), 72'(rd_data[71:64]));
			end
		end
	endtask

	// ==========
	// Sequence
	initial begin
		rst_n = 1'h0;
		two_car = 1'h0;
		odd_car = 1'h0;
		ctrl = sdram_mux_pkg::CTRL_RESET;
		wr_data = sdram_mux_pkg::WORD_RESET;
		pat = '0;
		bad_count = 0;
		checks = 0;
		repeat (10) @(negedge sys_clk);
		cmp_w("ctrl_a", 72'(sdram_mux_pkg::CTRL_RESET), 72'(ctrl_a));
		cmp_w("rd_data", sdram_mux_pkg::WORD_RESET, rd_data);
		cmp_f("dq_oe", 4'h0, dq_oe);
		cmp_f("rd_oe", 4'h0, {3'h0, rd_oe});
		rst_n = 1'h1;
		for (int i = 0; i < 8; i++) begin
			run_row(rows[i], i);
		end
		// Reset in the middle of a write burst
		@(negedge sys_clk);
		ctrl = mk(2'h1, 1'h0, 3);
		two_car = 1'h0;
		@(negedge sys_clk);
		ctrl = sdram_mux_pkg::CTRL_RESET;
		repeat (3) @(negedge sys_clk);
		rst_n = 1'h0;
		#1;
		cmp_f("dq_oe", 4'h0, dq_oe);
		cmp_f("rd_oe", 4'h0, {3'h0, rd_oe});
		@(negedge sys_clk);
		rst_n = 1'h1;
		run_row(rows[0], 9);
		run_row(rows[1], 10);
		final_report();
	end
endmodule // tb
